//--- common/lpmc_regs.vh
// register offsets, fields, reset values and timing counts of the low-power mode controller
`ifndef LPMC_REGS_VH
`define LPMC_REGS_VH
`define LPMC_CTRL_OFF 12'h000
`define LPMC_FSTART_OFF 12'h004
`define LPMC_WAKE_EN_OFF 12'h008
`define LPMC_DEBOUNCE_OFF 12'h00C
`define LPMC_STATUS_OFF 12'h010
`define LPMC_WAKE_CAUSE_OFF 12'h014
`define LPMC_PERIPH_OFF 12'h018
`define LPMC_CTRL_RST 32'h0000_0000
`define LPMC_FSTART_RST 32'h0000_0000
`define LPMC_WAKE_EN_RST 32'h0000_0000
`define LPMC_DEBOUNCE_RST 32'h0000_0000
`define LPMC_PERIPH_RST 32'h0000_0000
`define LPMC_CTRL_DEEP_BIT 0
`define LPMC_CTRL_XTAL_BIT 1
`define LPMC_CTRL_REG_DIS_BIT 2
`define LPMC_CTRL_CLKSRC_LSB 4
`define LPMC_FSTART_LP_BIT 16
`define LPMC_EN_MON_BIT 16
`define LPMC_EN_RTC_BIT 17
`define LPMC_EN_TICK_BIT 18
`define LPMC_EN_USB_BIT 19
`define LPMC_DEB_LSB 0
`define LPMC_DEB_W 8
// resynchronisation delay before wait mode takes effect, in ns
`define LPMC_RESYNC_NS 200
`define LPMC_CLK_NS 25
`define LPMC_RESYNC_CYC ((`LPMC_RESYNC_NS + `LPMC_CLK_NS - 1) / `LPMC_CLK_NS)
// supply ramp wait on wake, in ns (start-up under 100 us, shortest count kept at 1 cycle at least)
`define LPMC_RAMP_NS 100000
`define LPMC_RAMP_CYC (`LPMC_RAMP_NS / `LPMC_CLK_NS)
`endif

//--- core/lpmc_top.v
// low-power mode controller: mode decode, clock and supply gating, wake sequencing, APB registers
//
// Overview of operation
// - wait-for-event with deep sleep enters backup
// - any enabled wake pin, supply monitor, RTC or tick alarm leaves backup (USB wake does not)
// - wake pins transition-triggered with configurable debounce
// - backup keeps slow domain, core supply off
// - software picks RC or crystal slow clock
// - regulator output pulled to ground in backup
// - I/O held in backup, pulled-up inputs after
// - wait stops core, peripheral, memory clocks
// - wait-for-event with low-power select and deep sleep clear enters wait
// - fast-start pins, RTC and tick alarms, USB wake wait
// - sleep stops only the core clock
// - sleep on wfi, or on wfe with both selects clear
// - wfi wakes on interrupt, wfe on event
// - active clock source chosen, peripherals gated
// - regulator disable separate from backup
// - wake sequence re-enables core and SRAM supply
// - fast start restarts RC, switches clock, core
`timescale 1ns/1ps
`include "lpmc_regs.vh"
module lpmc_top (
    pclk,
    presetn,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    wfe_req,
    wfi_req,
    irq_pending,
    event_in,
    wake_pins,
    supply_monitor_alarm,
    rtc_alarm,
    tick_timer_alarm,
    usb_wake,
    core_clk_en,
    periph_clk_en,
    mem_clk_en,
    core_supply_on,
    sram_supply_on,
    regulator_on,
    regulator_pulldown,
    slow_clk_xtal,
    fast_rc_enable,
    main_clk_sel,
    backup_reset,
    io_hold,
    io_pullup_in,
    mode
);
    input wire pclk;
    input wire presetn;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [11:0] paddr;
    input wire [31:0] pwdata;
    output reg [31:0] prdata;
    output wire pready;
    output wire pslverr;
    input wire wfe_req;
    input wire wfi_req;
    input wire irq_pending;
    input wire event_in;
    input wire [15:0] wake_pins;
    input wire supply_monitor_alarm;
    input wire rtc_alarm;
    input wire tick_timer_alarm;
    input wire usb_wake;
    output reg core_clk_en;
    output reg [31:0] periph_clk_en;
    output reg mem_clk_en;
    output reg core_supply_on;
    output reg sram_supply_on;
    output reg regulator_on;
    output reg regulator_pulldown;
    output reg slow_clk_xtal;
    output reg fast_rc_enable;
    output reg [1:0] main_clk_sel;
    output reg backup_reset;
    output reg io_hold;
    output reg io_pullup_in;
    output reg [2:0] mode;

    // one-hot states
    localparam ST_ACTIVE = 7'b0000001;
    localparam ST_RESYNC = 7'b0000010;
    localparam ST_WAIT = 7'b0000100;
    localparam ST_SLEEP = 7'b0001000;
    localparam ST_BACKUP = 7'b0010000;
    localparam ST_RAMP = 7'b0100000;
    localparam ST_RESTART = 7'b1000000;
    localparam [16:0] RESYNC_CYC = `LPMC_RESYNC_CYC;
    localparam [16:0] RAMP_CYC = `LPMC_RAMP_CYC;
    localparam [1:0] CLK_FAST_RC = 2'h0;

    reg [31:0] ctrl_reg;
    reg [31:0] fstart_reg;
    reg [31:0] wake_en_reg;
    reg [31:0] deb_reg;
    reg [31:0] periph_reg;
    reg [31:0] cause_reg;
    reg [6:0] state_reg;
    reg [16:0] cnt_reg;
    reg sleep_by_wfi_reg;
    reg [4:0] sync1_reg;
    reg [4:0] sync2_reg;

    wire [15:0] pin_level;
    wire [15:0] pin_change;
    wire wr_en;
    wire rd_en;
    wire addr_ok;
    wire deep_sleep_select;
    wire low_power_select;
    wire monitor_s;
    wire rtc_s;
    wire tick_s;
    wire usb_s;
    wire evt_s;
    wire backup_wake;
    wire fast_wake;
    wire [31:0] status_word;

    ////////////////////////////////////////////////////////////////////////////////
    // input synchronisers; sleep requests come from core logic on pclk and need none
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
        end else begin
            sync1_reg <= {event_in, usb_wake, tick_timer_alarm, rtc_alarm, supply_monitor_alarm};
            sync2_reg <= sync1_reg;
        end
    end
    assign monitor_s = sync2_reg[0];
    assign rtc_s = sync2_reg[1];
    assign tick_s = sync2_reg[2];
    assign usb_s = sync2_reg[3];
    assign evt_s = sync2_reg[4];

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_pin
            lpmc_wake_filter u_filt (
                .pclk(pclk),
                .presetn(presetn),
                .pin(wake_pins[gi]),
                .deb_len(deb_reg[`LPMC_DEB_LSB +: `LPMC_DEB_W]),
                .level(pin_level[gi]),
                .change(pin_change[gi])
            );
        end
    endgenerate

    // backup exits on a debounced level transition of an enabled pin
    assign backup_wake = (|(pin_change & wake_en_reg[15:0])) |
        (monitor_s & wake_en_reg[`LPMC_EN_MON_BIT]) |
        (rtc_s & wake_en_reg[`LPMC_EN_RTC_BIT]) |
        (tick_s & wake_en_reg[`LPMC_EN_TICK_BIT]);
    // fast start inputs are low-level active
    assign fast_wake = (|(~pin_level & fstart_reg[15:0])) |
        (rtc_s & wake_en_reg[`LPMC_EN_RTC_BIT]) |
        (tick_s & wake_en_reg[`LPMC_EN_TICK_BIT]) |
        (usb_s & wake_en_reg[`LPMC_EN_USB_BIT]);

    assign deep_sleep_select = ctrl_reg[`LPMC_CTRL_DEEP_BIT];
    assign low_power_select = fstart_reg[`LPMC_FSTART_LP_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    assign pready = 1'b1;
    assign addr_ok = (paddr == `LPMC_CTRL_OFF) || (paddr == `LPMC_FSTART_OFF) ||
        (paddr == `LPMC_WAKE_EN_OFF) || (paddr == `LPMC_DEBOUNCE_OFF) ||
        (paddr == `LPMC_STATUS_OFF) || (paddr == `LPMC_WAKE_CAUSE_OFF) ||
        (paddr == `LPMC_PERIPH_OFF);
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_en = psel & penable & pwrite & addr_ok;
    assign rd_en = psel & ~penable & ~pwrite;
    assign status_word = {16'h0000, pin_level[15:9], state_reg, fast_rc_enable, core_supply_on};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `LPMC_CTRL_RST;
            fstart_reg <= `LPMC_FSTART_RST;
            wake_en_reg <= `LPMC_WAKE_EN_RST;
            deb_reg <= `LPMC_DEBOUNCE_RST;
            periph_reg <= `LPMC_PERIPH_RST;
            prdata <= 32'h0000_0000;
        end else begin
            if (wr_en) begin
                case (paddr)
                    `LPMC_CTRL_OFF: ctrl_reg <= pwdata;
                    `LPMC_FSTART_OFF: fstart_reg <= pwdata;
                    `LPMC_WAKE_EN_OFF: wake_en_reg <= pwdata;
                    `LPMC_DEBOUNCE_OFF: deb_reg <= pwdata;
                    `LPMC_PERIPH_OFF: periph_reg <= pwdata;
                    default: ctrl_reg <= ctrl_reg;
                endcase
            end
            // read data is latched in the setup cycle so it comes from a flop
            if (rd_en) begin
                case (paddr)
                    `LPMC_CTRL_OFF: prdata <= ctrl_reg;
                    `LPMC_FSTART_OFF: prdata <= fstart_reg;
                    `LPMC_WAKE_EN_OFF: prdata <= wake_en_reg;
                    `LPMC_DEBOUNCE_OFF: prdata <= deb_reg;
                    `LPMC_STATUS_OFF: prdata <= status_word;
                    `LPMC_WAKE_CAUSE_OFF: prdata <= cause_reg;
                    `LPMC_PERIPH_OFF: prdata <= periph_reg;
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // mode sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_ACTIVE;
            cnt_reg <= 17'h00000;
            sleep_by_wfi_reg <= 1'b0;
            cause_reg <= 32'h0000_0000;
            backup_reset <= 1'b0;
        end else begin
            backup_reset <= 1'b0;
            // cause bits are sticky; a new wake wins over a software clear
            if (wr_en && paddr == `LPMC_WAKE_CAUSE_OFF) begin
                cause_reg <= cause_reg & ~pwdata;
            end
            case (state_reg)
                ST_ACTIVE: begin
                    if (wfe_req && deep_sleep_select) begin
                        state_reg <= ST_BACKUP;
                    end else if (wfe_req && low_power_select) begin
                        state_reg <= ST_RESYNC;
                        cnt_reg <= RESYNC_CYC;
                    end else if (wfe_req || wfi_req) begin
                        state_reg <= ST_SLEEP;
                        sleep_by_wfi_reg <= wfi_req & ~wfe_req;
                    end
                end
                ST_RESYNC: begin
                    // main clock resynchronisation before wait truly takes effect
                    if (cnt_reg <= 17'h00001) begin
                        state_reg <= ST_WAIT;
                    end else begin
                        cnt_reg <= cnt_reg - 17'h00001;
                    end
                end
                ST_WAIT: begin
                    if (fast_wake) begin
                        state_reg <= ST_RESTART;
                        cause_reg <= cause_reg | {16'h0001, 16'h0000};
                    end
                end
                ST_SLEEP: begin
                    if (sleep_by_wfi_reg ? irq_pending : (irq_pending | evt_s | fast_wake)) begin
                        state_reg <= ST_ACTIVE;
                    end
                end
                ST_BACKUP: begin
                    if (backup_wake) begin
                        state_reg <= ST_RAMP;
                        cnt_reg <= RAMP_CYC;
                        cause_reg <= cause_reg | {13'h0000, tick_s, rtc_s, monitor_s, pin_change};
                    end
                end
                ST_RAMP: begin
                    if (cnt_reg <= 17'h00001) begin
                        state_reg <= ST_RESTART;
                        backup_reset <= 1'b1; // core comes back through reset
                    end else begin
                        cnt_reg <= cnt_reg - 17'h00001;
                    end
                end
                ST_RESTART: begin
                    state_reg <= ST_ACTIVE;
                end
                default: state_reg <= ST_ACTIVE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // clock, supply and I/O outputs, all registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_clk_en <= 1'b1;
            periph_clk_en <= 32'h0000_0000;
            mem_clk_en <= 1'b1;
            core_supply_on <= 1'b1;
            sram_supply_on <= 1'b1;
            regulator_on <= 1'b1;
            regulator_pulldown <= 1'b0;
            slow_clk_xtal <= 1'b0;
            fast_rc_enable <= 1'b1;
            main_clk_sel <= CLK_FAST_RC;
            io_hold <= 1'b0;
            io_pullup_in <= 1'b1;
            mode <= 3'h0;
        end else begin
            slow_clk_xtal <= ctrl_reg[`LPMC_CTRL_XTAL_BIT];
            main_clk_sel <= ctrl_reg[`LPMC_CTRL_CLKSRC_LSB +: 2];
            periph_clk_en <= periph_reg;
            core_clk_en <= 1'b1;
            mem_clk_en <= 1'b1;
            fast_rc_enable <= 1'b1;
            core_supply_on <= 1'b1;
            sram_supply_on <= 1'b1;
            regulator_on <= ~ctrl_reg[`LPMC_CTRL_REG_DIS_BIT];
            regulator_pulldown <= 1'b0;
            io_hold <= 1'b0;
            mode <= 3'h0;
            case (state_reg)
                ST_RESYNC: begin
                    fast_rc_enable <= 1'b0;
                end
                ST_WAIT: begin
                    core_clk_en <= 1'b0;
                    mem_clk_en <= 1'b0;
                    periph_clk_en <= 32'h0000_0000;
                    fast_rc_enable <= 1'b0;
                    mode <= 3'h2;
                end
                ST_SLEEP: begin
                    core_clk_en <= 1'b0;
                    mode <= 3'h4;
                end
                ST_BACKUP: begin
                    core_clk_en <= 1'b0;
                    mem_clk_en <= 1'b0;
                    periph_clk_en <= 32'h0000_0000;
                    fast_rc_enable <= 1'b0;
                    core_supply_on <= 1'b0;
                    sram_supply_on <= 1'b0;
                    regulator_on <= 1'b0;
                    regulator_pulldown <= 1'b1;
                    io_hold <= 1'b1;
                    io_pullup_in <= 1'b0;
                    mode <= 3'h1;
                end
                ST_RAMP: begin
                    core_clk_en <= 1'b0;
                    mem_clk_en <= 1'b0;
                    periph_clk_en <= 32'h0000_0000;
                    io_hold <= 1'b1;
                    regulator_on <= 1'b1;
                end
                ST_RESTART: begin
                    main_clk_sel <= CLK_FAST_RC;
                    io_hold <= 1'b0;
                end
                default: begin
                    core_clk_en <= 1'b1;
                end
            endcase
            if (backup_reset) begin
                io_pullup_in <= 1'b1;
            end
        end
    end
endmodule

//--- core/lpmc_wake_filter.v
// one wake pin: two-flop synchroniser, debounce filter, level-transition detect
`timescale 1ns/1ps
module lpmc_wake_filter (
    pclk,
    presetn,
    pin,
    deb_len,
    level,
    change
);
    input wire pclk;
    input wire presetn;
    input wire pin;
    input wire [7:0] deb_len;
    output reg level;
    output wire change;

    reg sync1_reg;
    reg sync2_reg;
    reg [7:0] cnt_reg;
    reg level_d_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            cnt_reg <= 8'h00;
            level <= 1'b1;
            level_d_reg <= 1'b1;
        end else begin
            sync1_reg <= pin;
            sync2_reg <= sync1_reg;
            level_d_reg <= level;
            // a new level must hold for deb_len plus one cycles before it is believed
            if (sync2_reg == level) begin
                cnt_reg <= 8'h00;
            end else if (cnt_reg >= deb_len) begin
                level <= sync2_reg;
                cnt_reg <= 8'h00;
            end else begin
                cnt_reg <= cnt_reg + 8'h01;
            end
        end
    end

    assign change = level ^ level_d_reg;
endmodule

//--- dv/lpmc_core_model.sv
// processor core model: issues one-cycle wait-for-event and wait-for-interrupt requests
`timescale 1ns/1ps
module lpmc_core_model (
    input wire logic pclk,
    output logic wfe_req,
    output logic wfi_req
);
    initial begin
        wfe_req = 1'b0;
        wfi_req = 1'b0;
    end
    // a request stands one cycle only, as a retiring instruction gives it
    task automatic issue(input logic use_wfi);
        @(posedge pclk);
        wfe_req <= !use_wfi;
        wfi_req <= use_wfi;
        @(posedge pclk);
        wfe_req <= 1'b0;
        wfi_req <= 1'b0;
    endtask
endmodule

//--- dv/lpmc_top_assertions.sv
// concurrent checks on the ports of the low-power mode controller
`timescale 1ns/1ps
`include "lpmc_regs.vh"
module lpmc_checker (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic wfe_req,
    input logic wfi_req,
    input logic irq_pending,
    input logic core_clk_en,
    input logic mem_clk_en,
    input logic core_supply_on,
    input logic sram_supply_on,
    input logic regulator_on,
    input logic regulator_pulldown,
    input logic fast_rc_enable,
    input logic backup_reset,
    input logic io_hold,
    input logic io_pullup_in,
    input logic [2:0] mode
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic deep_q, lp_q, by_wfi;
    wire wr = psel && penable && pwrite;
    // select bits are shadowed from the bus, since they are not visible at the ports
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deep_q <= 1'b0;
            lp_q <= 1'b0;
            by_wfi <= 1'b0;
        end else begin
            if (wr && paddr == `LPMC_CTRL_OFF) deep_q <= pwdata[`LPMC_CTRL_DEEP_BIT];
            if (wr && paddr == `LPMC_FSTART_OFF) lp_q <= pwdata[`LPMC_FSTART_LP_BIT];
            if (mode == 3'd0 && (wfe_req || wfi_req)) by_wfi <= !wfe_req;
        end
    end
    sequence s_req_wfe;
        mode == 3'd0 && wfe_req;
    endsequence
    sequence s_req_wfi;
        mode == 3'd0 && wfi_req && !wfe_req;
    endsequence
    property p_backup_entry;
        s_req_wfe ##0 deep_q |-> ##[1:3] mode == 3'd1;
    endproperty
    a_backup_entry: assert property (p_backup_entry) else $error("backup not entered");
    property p_deep_wins;
        s_req_wfe ##0 (deep_q && lp_q) |-> ##[1:3] mode == 3'd1;
    endproperty
    a_deep_wins: assert property (p_deep_wins) else $error("deep sleep lost priority");
    property p_wait_entry;
        s_req_wfe ##0 (!deep_q && lp_q) |-> ##[1:3] !fast_rc_enable ##[1:14] mode == 3'd2;
    endproperty
    a_wait_entry: assert property (p_wait_entry) else $error("wait not entered");
    property p_sleep_entry;
        (s_req_wfi or (s_req_wfe ##0 (!deep_q && !lp_q))) |-> ##[1:3] mode == 3'd4;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");
    property p_wait_gates;
        mode == 3'd2 |-> !core_clk_en && !mem_clk_en && core_supply_on && sram_supply_on;
    endproperty
    a_wait_gates: assert property (p_wait_gates) else $error("wait gating wrong");
    property p_sleep_gates;
        mode == 3'd4 |-> !core_clk_en && mem_clk_en && core_supply_on;
    endproperty
    a_sleep_gates: assert property (p_sleep_gates) else $error("sleep gating wrong");
    property p_backup_off;
        mode == 3'd1 |-> !core_supply_on && !regulator_on && regulator_pulldown;
    endproperty
    a_backup_off: assert property (p_backup_off) else $error("backup supplies wrong");
    property p_backup_io;
        mode == 3'd1 |-> io_hold && !io_pullup_in;
    endproperty
    a_backup_io: assert property (p_backup_io) else $error("io not held in backup");
    property p_pullup_after;
        backup_reset |-> ##[0:2] io_pullup_in;
    endproperty
    a_pullup_after: assert property (p_pullup_after) else $error("io pull-up missing after reset");
    property p_wake_supply;
        backup_reset |-> core_supply_on && sram_supply_on;
    endproperty
    a_wake_supply: assert property (p_wake_supply) else $error("supplies off at wake");
    property p_wfi_hold;
        mode == 3'd4 && by_wfi && !irq_pending && !$past(irq_pending) && !$past(irq_pending, 2)
            && !$past(irq_pending, 3) |=> mode == 3'd4;
    endproperty
    a_wfi_hold: assert property (p_wfi_hold) else $error("sleep left without interrupt");
    property p_restart;
        mode == 3'd2 ##1 mode != 3'd2 |-> ##[0:3] (fast_rc_enable && core_clk_en && mode == 3'd0);
    endproperty
    a_restart: assert property (p_restart) else $error("fast restart incomplete");
    property p_regdis;
        mode == 3'd0 && !regulator_on |-> !regulator_pulldown;
    endproperty
    a_regdis: assert property (p_regdis) else $error("regulator disable looks like backup");
endmodule
bind lpmc_top lpmc_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .wfe_req,
    .wfi_req, .irq_pending, .core_clk_en, .mem_clk_en, .core_supply_on, .sram_supply_on, .regulator_on,
    .regulator_pulldown, .fast_rc_enable, .backup_reset, .io_hold, .io_pullup_in, .mode);

//--- dv/lpmc_top_test.sv
// self-checking testbench of the low-power mode controller
`timescale 1ns/1ps
`include "lpmc_regs.vh"
module lpmc_top_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic err, irq_pending = 0, event_in = 0, usb_wake = 0;
    logic supply_monitor_alarm = 0, rtc_alarm = 0, tick_timer_alarm = 0;
    logic [15:0] wake_pins = 16'hFFFF;
    wire [31:0] prdata, periph_clk_en;
    wire pready, pslverr, wfe_req, wfi_req, core_clk_en, mem_clk_en, core_supply_on, sram_supply_on;
    wire regulator_on, regulator_pulldown, slow_clk_xtal, fast_rc_enable, backup_reset, io_hold, io_pullup_in;
    wire [1:0] main_clk_sel;
    wire [2:0] mode;
    int n_errors = 0, num_checks = 0;
    lpmc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .wfe_req, .wfi_req, .irq_pending, .event_in, .wake_pins, .supply_monitor_alarm, .rtc_alarm,
        .tick_timer_alarm, .usb_wake, .core_clk_en, .periph_clk_en, .mem_clk_en, .core_supply_on,
        .sram_supply_on, .regulator_on, .regulator_pulldown, .slow_clk_xtal, .fast_rc_enable, .main_clk_sel,
        .backup_reset, .io_hold, .io_pullup_in, .mode);
    lpmc_core_model core_u (.pclk, .wfe_req, .wfi_req);
    initial forever #12.5 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("n_errors %0d num_checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        i = 0;
        do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin n_errors++; end_of_test; end
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic wait_mode(input logic [2:0] m, input int n);
        int i;
        for (i = 0; i < n && mode !== m; i++) @(posedge pclk);
        chk("mode", mode, m);
        if (mode !== m) end_of_test;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [11:0] offs [5] = '{`LPMC_CTRL_OFF, `LPMC_FSTART_OFF, `LPMC_WAKE_EN_OFF, `LPMC_DEBOUNCE_OFF,
            `LPMC_PERIPH_OFF};
        foreach (offs[k]) begin apb(0, offs[k], 0); chk("reset value", rd, 32'h0000_0000); end
        apb(0, 12'h01C, 0);
        chk("unmapped err", err, 1);
        chk("unmapped data", rd, 32'h0000_0000);
        apb(1, `LPMC_CTRL_OFF, 32'h0000_0036);
        apb(0, `LPMC_CTRL_OFF, 0);
        chk("ctrl", rd, 32'h0000_0036);
        repeat (3) @(posedge pclk);
        chk("slow_clk_xtal", slow_clk_xtal, 1);
        chk("regulator_on", regulator_on, 0);
        chk("regulator_pulldown", regulator_pulldown, 0);
        chk("main_clk_sel", main_clk_sel, 2'h3);
        apb(1, `LPMC_CTRL_OFF, 0);
        apb(1, `LPMC_PERIPH_OFF, 32'h0000_00A5);
        repeat (3) @(posedge pclk);
        chk("periph_clk_en", periph_clk_en, 32'h0000_00A5);
    endtask
    task automatic t_sleep(input logic wfi);
        apb(1, `LPMC_FSTART_OFF, 0);
        core_u.issue(wfi);
        wait_mode(3'd4, 6);
        chk("core_clk_en", core_clk_en, 0);
        chk("mem_clk_en", mem_clk_en, 1);
        chk("periph_clk_en", periph_clk_en, 32'h0000_00A5);
        event_in <= 1;
        if (wfi) begin
            repeat (10) @(posedge pclk);
            chk("mode", mode, 3'd4);
            event_in <= 0;
            irq_pending <= 1;
        end
        wait_mode(3'd0, 10);
        irq_pending <= 0;
        event_in <= 0;
        repeat (4) @(posedge pclk);
    endtask
    task automatic t_wait(input int s);
        int i;
        apb(1, `LPMC_FSTART_OFF, 32'h0001_0001);
        apb(1, `LPMC_WAKE_EN_OFF, 32'h000E_0000);
        core_u.issue(0);
        // software waits for the oscillator enable to drop so no stray instruction runs
        for (i = 0; i < 20 && fast_rc_enable !== 1'b0; i++) @(posedge pclk);
        chk("fast_rc_enable", fast_rc_enable, 0);
        if (fast_rc_enable !== 1'b0) end_of_test;
        wait_mode(3'd2, 20);
        chk("clocks", {core_clk_en, mem_clk_en, |periph_clk_en}, 0);
        chk("supplies", {core_supply_on, sram_supply_on}, 2'h3);
        case (s)
            0: usb_wake <= 1;
            1: rtc_alarm <= 1;
            2: tick_timer_alarm <= 1;
            default: wake_pins[0] <= 0;
        endcase
        wait_mode(3'd0, 20);
        chk("restart", {fast_rc_enable, main_clk_sel, core_clk_en}, 4'h9);
        usb_wake <= 0;
        rtc_alarm <= 0;
        tick_timer_alarm <= 0;
        wake_pins <= 16'hFFFF;
        repeat (6) @(posedge pclk);
    endtask
    task automatic t_backup;
        int i;
        apb(1, `LPMC_WAKE_EN_OFF, 32'h0000_0008);
        apb(1, `LPMC_DEBOUNCE_OFF, 32'h0000_0002);
        apb(1, `LPMC_CTRL_OFF, 32'h0000_0001);
        core_u.issue(0);
        wait_mode(3'd1, 6);
        chk("backup supplies", {core_supply_on, regulator_on, regulator_pulldown}, 3'h1);
        chk("backup io", {io_hold, io_pullup_in}, 2'h2);
        // a two-cycle glitch on an enabled pin and a lasting change on a disabled pin must both be ignored
        wake_pins <= 16'hFFD7;
        repeat (2) @(posedge pclk);
        wake_pins <= 16'hFFDF;
        repeat (20) @(posedge pclk);
        chk("mode", mode, 3'd1);
        wake_pins <= 16'hFFFF;
        repeat (10) @(posedge pclk);
        wake_pins[3] <= 0;
        for (i = 0; i < 4300 && backup_reset !== 1'b1; i++) @(posedge pclk);
        chk("backup_reset", backup_reset, 1);
        if (backup_reset !== 1'b1) end_of_test;
        chk("wake supplies", {core_supply_on, sram_supply_on}, 2'h3);
        wait_mode(3'd0, 10);
        // hold drops and the pull-up returns one edge after the reset pulse
        repeat (2) @(posedge pclk);
        chk("io after wake", {io_hold, io_pullup_in, regulator_on}, 3'h3);
        apb(0, `LPMC_WAKE_CAUSE_OFF, 0);
        chk("wake cause", rd & 32'h0000_0008, 32'h0000_0008);
        apb(1, `LPMC_WAKE_CAUSE_OFF, 32'hFFFF_FFFF);
        apb(0, `LPMC_WAKE_CAUSE_OFF, 0);
        chk("wake cause cleared", rd & 32'h0000_0008, 32'h0000_0000);
        wake_pins <= 16'hFFFF;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        t_regs;
        t_sleep(1);
        t_sleep(0);
        for (int s = 0; s < 4; s++) t_wait(s);
        t_backup;
        end_of_test;
    end
endmodule
